// ===== smc_defs.svh
// timing constants for the 16x4 asynchronous memory controller
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH

`define SMC_CLK_PERIOD_PS        5000
`define SMC_ADDR_W               4
`define SMC_DATA_W               4
`define SMC_WORDS                16
// times in picoseconds, as printed in ns
`define SMC_ADDR_SETUP_PS        3000
`define SMC_ADDR_HOLD_PS         2000
`define SMC_DATA_SETUP_PS        13000
`define SMC_DATA_HOLD_PS         2000
`define SMC_CE_SETUP_PS          3000
`define SMC_CE_HOLD_PS           2000
`define SMC_STROBE_WIDTH_PS      10000
`define SMC_ACCESS_INV_PS        15000
`define SMC_ACCESS_NONINV_PS     10000
// least times round up, at least one cycle
`define SMC_CYC_UP(t)            (((t) + `SMC_CLK_PERIOD_PS - 1) / `SMC_CLK_PERIOD_PS)
`define SMC_SETUP_CYC            `SMC_CYC_UP(`SMC_ADDR_SETUP_PS)
`define SMC_HOLD_CYC             `SMC_CYC_UP(`SMC_ADDR_HOLD_PS)
`define SMC_STROBE_CYC           `SMC_CYC_UP(`SMC_STROBE_WIDTH_PS)
`define SMC_DSETUP_CYC           `SMC_CYC_UP(`SMC_DATA_SETUP_PS)
`define SMC_ACC_INV_CYC          `SMC_CYC_UP(`SMC_ACCESS_INV_PS)
`define SMC_ACC_NONINV_CYC       `SMC_CYC_UP(`SMC_ACCESS_NONINV_PS)
`define SMC_CNT_W                3

`endif

// ===== smc_pkg.sv
// types for the 16x4 asynchronous memory controller
package smc_pkg;
  typedef enum logic [2:0]
  {
    SMC_IDLE  = 3'h0,
    SMC_SETUP = 3'h1,
    SMC_PULSE = 3'h3,
    SMC_HOLD  = 3'h2,
    SMC_READ  = 3'h6
  } smc_state_t;
endpackage

// ===== smc_timer.sv
// down counter that marks the end of a phase
`timescale 1ns/10ps
`default_nettype none
`include "smc_defs.svh"

module smc_timer
(
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_load,
  input  wire logic [`SMC_CNT_W-1:0] i_count,
  output logic                       o_done
);
  logic [`SMC_CNT_W-1:0] cnt_q;

  assign o_done = (cnt_q == 3'h0);

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      cnt_q <= 3'h0;
    else if (i_load)
      cnt_q <= i_count;
    else if (!o_done)
      cnt_q <= cnt_q - 3'h1;
  end
endmodule

`default_nettype wire

// ===== smc_ctrl.sv
// controller driving a 16x4 asynchronous static memory over its pins
`timescale 1ns/10ps
`default_nettype none
`include "smc_defs.svh"

module smc_ctrl
#(
  parameter bit INVERTING = 1'b1
)
(
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  input  wire logic                   i_req,
  input  wire logic                   i_we,
  input  wire logic [`SMC_ADDR_W-1:0] i_addr,
  input  wire logic [`SMC_DATA_W-1:0] i_wdata,
  output logic                        o_ready,
  output logic                        o_done,
  output logic [`SMC_DATA_W-1:0]      o_rdata,
  output logic [`SMC_ADDR_W-1:0]      o_mem_addr,
  output logic                        o_mem_ce_n,
  output logic                        o_mem_we_n,
  output logic [`SMC_DATA_W-1:0]      o_mem_din,
  input  wire logic [`SMC_DATA_W-1:0] i_mem_q
);
  // ==========================================================
  // phase lengths
  // the timer counts down to zero, so a phase of n cycles loads n - 1
  // and ends in the cycle in which the count reads zero
  localparam logic [`SMC_CNT_W-1:0] SETUP_N  = `SMC_CNT_W'(`SMC_SETUP_CYC - 1);
  // the strobe covers its own least width and the data setup to its rise
  localparam int STROBE_I = (`SMC_STROBE_CYC > `SMC_DSETUP_CYC) ?
                            `SMC_STROBE_CYC : `SMC_DSETUP_CYC;
  localparam logic [`SMC_CNT_W-1:0] STROBE_N = `SMC_CNT_W'(STROBE_I - 1);
  localparam logic [`SMC_CNT_W-1:0] HOLD_N   = `SMC_CNT_W'(`SMC_HOLD_CYC - 1);
  localparam int ACC_I = INVERTING ? `SMC_ACC_INV_CYC : `SMC_ACC_NONINV_CYC;
  // one more cycle since read data is registered at the end
  localparam logic [`SMC_CNT_W-1:0] ACC_N    = `SMC_CNT_W'(ACC_I);

  // ==========================================================
  // state and pin registers
  smc_pkg::smc_state_t            state_q;
  smc_pkg::smc_state_t            state_d;
  logic [`SMC_ADDR_W-1:0]         addr_q;
  logic [`SMC_DATA_W-1:0]         din_q;
  logic                           ce_n_q;
  logic                           we_n_q;
  logic                           ready_q;
  logic                           done_q;
  logic [`SMC_DATA_W-1:0]         rdata_q;
  logic                           t_load;
  logic [`SMC_CNT_W-1:0]          t_count;
  logic                           t_done;

  wire                            take     = ready_q && i_req;
  wire  [`SMC_DATA_W-1:0]         q_fixed  = INVERTING ? ~i_mem_q : i_mem_q;
  wire                            in_idle  = (state_q == smc_pkg::SMC_IDLE);
  wire                            in_setup = (state_q == smc_pkg::SMC_SETUP);
  wire                            in_pulse = (state_q == smc_pkg::SMC_PULSE);
  wire                            in_hold  = (state_q == smc_pkg::SMC_HOLD);
  wire                            in_read  = (state_q == smc_pkg::SMC_READ);

  // ==========================================================
  // phase ends, each one cycle wide
  wire                            setup_end = in_setup && t_done;
  wire                            pulse_end = in_pulse && t_done;
  wire                            finish    = (in_hold || in_read) && t_done;
  wire                            capture   = in_read && t_done;

  smc_timer u_timer
  (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_load  (t_load),
    .i_count (t_count),
    .o_done  (t_done)
  );

  // ==========================================================
  // sequencing
  // requests are taken only from idle; every other state keeps ready low,
  // and a phase that ends loads the next one in the same cycle
  always_comb
  begin
    state_d = state_q;
    t_load  = 1'b0;
    t_count = SETUP_N;
    case (state_q)
      smc_pkg::SMC_IDLE:
        if (take)
        begin
          t_load  = 1'b1;
          t_count = i_we ? SETUP_N : ACC_N;
          state_d = i_we ? smc_pkg::SMC_SETUP : smc_pkg::SMC_READ;
        end
      smc_pkg::SMC_SETUP:
        if (t_done)
        begin
          t_load  = 1'b1;
          t_count = STROBE_N;
          state_d = smc_pkg::SMC_PULSE;
        end
      smc_pkg::SMC_PULSE:
        if (t_done)
        begin
          t_load  = 1'b1;
          t_count = HOLD_N;
          state_d = smc_pkg::SMC_HOLD;
        end
      smc_pkg::SMC_HOLD:
        if (t_done)
          state_d = smc_pkg::SMC_IDLE;
      smc_pkg::SMC_READ:
        if (t_done)
          state_d = smc_pkg::SMC_IDLE;
      default:
        state_d = smc_pkg::SMC_IDLE;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      state_q <= smc_pkg::SMC_IDLE;
    else
      state_q <= state_d;
  end

  // ==========================================================
  // memory pins; address and data change only when idle
  // the next take comes a cycle after ce_n rises, which gives the hold time;
  // din is driven on reads too, where the memory ignores it
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      addr_q <= 4'h0;
      din_q  <= 4'h0;
    end
    else if (take)
    begin
      addr_q <= i_addr;
      din_q  <= i_wdata;
    end
  end

  // enable low through setup, strobe and hold, and through the read phase; high otherwise
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      ce_n_q <= 1'b1;
    else if (take)
      ce_n_q <= 1'b0;
    else if (finish)
      ce_n_q <= 1'b1;
  end

  // strobe falls after the setup phase and rises after the pulse phase
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      we_n_q <= 1'b1;
    else if (setup_end)
      we_n_q <= 1'b0;
    else if (pulse_end)
      we_n_q <= 1'b1;
  end

  // ==========================================================
  // user side
  // ready returns with done, so requests may follow back to back
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ready_q <= 1'b0;
      done_q  <= 1'b0;
    end
    else
    begin
      ready_q <= (in_idle && !take) || finish;
      done_q  <= finish;
    end
  end

  // read data is taken one cycle past the rounded access time and held
  // until the next read completes
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      rdata_q <= 4'h0;
    else if (capture)
      rdata_q <= q_fixed;
  end

  // ==========================================================
  // outputs, each straight from its register
  assign o_ready    = ready_q;
  assign o_done     = done_q;
  assign o_rdata    = rdata_q;
  assign o_mem_addr = addr_q;
  assign o_mem_ce_n = ce_n_q;
  assign o_mem_we_n = we_n_q;
  assign o_mem_din  = din_q;
endmodule

`default_nettype wire

// ===== smc_ctrl_asserts.sv
// checker on the controller's memory pins
`timescale 1ns/10ps
`default_nettype none
module smc_ctrl_asserts
#(
  parameter bit INVERTING = 1'b1
)
(
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic       i_req,
  input wire logic       i_we,
  input wire logic       o_ready,
  input wire logic       o_done,
  input wire logic [3:0] o_mem_addr,
  input wire logic       o_mem_ce_n,
  input wire logic       o_mem_we_n,
  input wire logic [3:0] o_mem_din
);
  localparam int RD_GAP = INVERTING ? 4 : 3;
  wire rd = o_ready && i_req && !i_we;
  wire wr = o_ready && i_req && i_we;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_strobe_width: assert property ($fell(o_mem_we_n) |-> !o_mem_we_n [*3] ##1 o_mem_we_n)
    else $error("strobe width");
  a_ce_setup: assert property ($fell(o_mem_we_n) |-> !$past(o_mem_ce_n) && $stable(o_mem_addr))
    else $error("setup before strobe");
  a_pins_steady: assert property (!o_mem_we_n |-> $stable(o_mem_din) && !o_mem_ce_n)
    else $error("pins moved in strobe");
  a_write_hold: assert property ($rose(o_mem_we_n) && !$past(i_rst) |-> !o_mem_ce_n ##1
    ($stable(o_mem_addr) && $stable(o_mem_din)))
    else $error("hold after strobe");
  a_idle_no_write: assert property (o_mem_ce_n |-> o_mem_we_n)
    else $error("strobe while disabled");
  a_write_seq: assert property (wr |=> o_mem_we_n && !o_mem_ce_n ##1 !o_mem_we_n ##4 o_done)
    else $error("write sequence");
  a_read_seq: assert property (rd |=> o_mem_we_n throughout (!o_mem_ce_n ##RD_GAP o_done))
    else $error("read sequence");
  a_done_release: assert property (o_done |-> o_mem_ce_n && o_ready ##1 !o_done)
    else $error("release at done");
endmodule
`default_nettype wire

// ===== smc_mem_model.sv
// behavioural 16x4 static memory with three-state outputs
`timescale 1ns/10ps
`default_nettype none
module smc_mem_model
#(
  parameter bit INVERTING = 1'b1
)
(
  input  wire logic [3:0] i_addr,
  input  wire logic       i_ce_n,
  input  wire logic       i_we_n,
  input  wire logic [3:0] i_din,
  output logic      [3:0] o_q
);
  localparam real ACC_NS = INVERTING ? 15.0 : 10.0;
  logic [3:0] cells [16];
  logic [3:0] last = 4'h0;
  logic [3:0] word_d;
  wire rd = !i_ce_n && i_we_n;
  // access delay and no latching: a new address shows after the delay
  assign #(ACC_NS) word_d = INVERTING ? ~cells[i_addr] : cells[i_addr];
  // floating outputs show the complement of the last value read, never that value itself
  assign o_q = rd ? word_d : ~last;
  always @(o_q) if (rd) last = o_q;
  always @(*) if (!i_ce_n && !i_we_n) cells[i_addr] = i_din;
endmodule
`default_nettype wire

// ===== sram_16x4_async_tb_top.sv
// bench: controller against a memory model
`timescale 1ns/10ps
`default_nettype none
module sram_16x4_async_tb_top;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_req = 1'b0;
  logic        i_we = 1'b0;
  logic [3:0]  i_addr = 4'h0;
  logic [3:0]  i_wdata = 4'h0;
  logic        o_ready, o_done, ce_n, we_n;
  logic [3:0]  o_rdata, addr, din, q, last_rd;
  logic [3:0]  ref_mem [16];
  logic [3:0]  exp_q [$];
  logic [3:0]  exp_b [$];
  logic        i_req_b = 1'b0;
  logic        rdy_b, done_b, ce_n_b, we_n_b;
  logic [3:0]  rdata_b, addr_b, din_b, q_b;
  logic [16:0] seed = 17'h156c5;
  int          fails = 0;
  int          cmp_count = 0;
  always #2.5 i_clk = ~i_clk;
  smc_ctrl #(.INVERTING(1'b1)) DUT (.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req), .i_we(i_we),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_ready(o_ready), .o_done(o_done), .o_rdata(o_rdata),
    .o_mem_addr(addr), .o_mem_ce_n(ce_n), .o_mem_we_n(we_n), .o_mem_din(din), .i_mem_q(q));
  smc_mem_model #(.INVERTING(1'b1)) u_mem (.i_addr(addr), .i_ce_n(ce_n), .i_we_n(we_n),
    .i_din(din), .o_q(q));
  // the non-inverting variant runs the same accesses beside the inverting one
  smc_ctrl #(.INVERTING(1'b0)) dut_b (.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req_b),
    .i_we(i_we), .i_addr(i_addr), .i_wdata(i_wdata), .o_ready(rdy_b), .o_done(done_b),
    .o_rdata(rdata_b), .o_mem_addr(addr_b), .o_mem_ce_n(ce_n_b), .o_mem_we_n(we_n_b),
    .o_mem_din(din_b), .i_mem_q(q_b));
  smc_mem_model #(.INVERTING(1'b0)) u_mem_b (.i_addr(addr_b), .i_ce_n(ce_n_b),
    .i_we_n(we_n_b), .i_din(din_b), .o_q(q_b));
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] s);
    cmp_count++;
    if (e !== s)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  // request stays up until taken; each controller's request drops at its own take edge
  task automatic acc(input logic w, input logic [3:0] a, input logic [3:0] d);
    int   n;
    logic sa, sb, ta, tb;
    n = 0;
    ta = 1'b0;
    tb = 1'b0;
    if (w)
      ref_mem[a] = d;
    else
      last_rd = ref_mem[a];
    exp_q.push_back(last_rd);
    exp_b.push_back(last_rd);
    @(posedge i_clk);
    i_req <= 1'b1;
    i_req_b <= 1'b1;
    i_we <= w;
    i_addr <= a;
    i_wdata <= d;
    while (!(ta && tb))
    begin
      @(negedge i_clk);
      n++;
      if (n > 40)
      begin
        fails++;
        test_done();
      end
      sa = !ta && (o_ready === 1'b1);
      sb = !tb && (rdy_b === 1'b1);
      @(posedge i_clk);
      if (sa)
        i_req <= 1'b0;
      if (sb)
        i_req_b <= 1'b0;
      ta = ta || sa;
      tb = tb || sb;
    end
  endtask
  always @(negedge i_clk)
  begin
    if (o_done === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk("spare done", 4'h0, 4'h1);
      else
        chk("rdata", exp_q.pop_front(), o_rdata);
    end
    if (done_b === 1'b1)
    begin
      if (exp_b.size() == 0)
        chk("spare done b", 4'h0, 4'h1);
      else
        chk("rdata b", exp_b.pop_front(), rdata_b);
    end
  end
  initial
  begin
    last_rd = 4'h0;
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    chk("ce_n in reset", 4'h1, {3'h0, ce_n});
    @(posedge i_clk);
    i_rst <= 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      seed = lfsr(seed);
      acc(1'b1, i[3:0], seed[3:0]);
    end
    for (int i = 15; i >= 0; i--)
      acc(1'b0, i[3:0], seed[7:4]);
    repeat (40)
    begin
      seed = lfsr(seed);
      acc(seed[8], seed[3:0], seed[7:4]);
    end
    @(posedge i_clk);
    i_req <= 1'b0;
    repeat (12) @(posedge i_clk);
    chk("notes left", 4'h0, 4'(exp_q.size()));
    chk("notes left b", 4'h0, 4'(exp_b.size()));
    test_done();
  end
endmodule
bind smc_ctrl smc_ctrl_asserts #(.INVERTING(INVERTING)) u_chk (.i_clk(i_clk), .i_rst(i_rst),
  .i_req(i_req), .i_we(i_we), .o_ready(o_ready), .o_done(o_done), .o_mem_addr(o_mem_addr),
  .o_mem_ce_n(o_mem_ce_n), .o_mem_we_n(o_mem_we_n), .o_mem_din(o_mem_din));
`default_nettype wire
